/* File: core/diopc_pkg.sv */
/*
 * shared constants and types of the discrete i/o and pulse channel block.
 * assumes a single 40 MHz clock domain and an axi4-lite register master.
 */
package diopc_pkg;

	// clock and timing
	localparam int CLK_HZ        = 40000000;
	localparam int MS_TIME       = 1;
	localparam int MS_CYCLES     = CLK_HZ / 1000 * MS_TIME;
	localparam int CALC_MS       = 500;
	localparam int CALC_CYCLES   = MS_CYCLES * CALC_MS;

	// register byte offsets
	localparam logic [7:0] OFS_OUT_CTRL   = 8'h00;
	localparam logic [7:0] OFS_PULSE_CTRL = 8'h04;
	localparam logic [7:0] OFS_PULSE_FAC  = 8'h08;
	localparam logic [7:0] OFS_PULSE_QTY  = 8'h0C;
	localparam logic [7:0] OFS_IN_CTRL    = 8'h10;
	localparam logic [7:0] OFS_DEBOUNCE   = 8'h14;
	localparam logic [7:0] OFS_SYS_IN     = 8'h18;
	localparam logic [7:0] OFS_STATUS     = 8'h1C;
	localparam logic [7:0] OFS_EVENTS     = 8'h20;

	// reset values
	localparam logic [31:0] RST_OUT_CTRL   = 32'h0000_0000;
	localparam logic [31:0] RST_PULSE_CTRL = 32'h0000_0000;
	localparam logic [31:0] RST_PULSE_FAC  = 32'h0001_0000;
	localparam logic [31:0] RST_IN_CTRL    = 32'h0000_0000;
	localparam logic [31:0] RST_DEBOUNCE   = 32'h0000_0000;

	localparam logic [1:0] AXI_OKAY   = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	// status source per output
	typedef enum logic [1:0] {
		DIOPC_SRC_CHECK = 2'h0,
		DIOPC_SRC_WARN  = 2'h1,
		DIOPC_SRC_ALARM = 2'h2,
		DIOPC_SRC_DIR   = 2'h3
	} diopc_src_t;

	// three-state test setting
	typedef enum logic [1:0] {
		DIOPC_TEST_OFF  = 2'h0,
		DIOPC_TEST_ON   = 2'h1,
		DIOPC_TEST_LOW  = 2'h2
	} diopc_test_t;

	// quantity counted by the pulse channel
	typedef enum logic [1:0] {
		DIOPC_QTY_VOL   = 2'h0,
		DIOPC_QTY_BASE  = 2'h1,
		DIOPC_QTY_MASS  = 2'h2,
		DIOPC_QTY_CO2   = 2'h3
	} diopc_qty_t;

	// assigned input function
	typedef enum logic [2:0] {
		DIOPC_FN_MAINT  = 3'h0,
		DIOPC_FN_CHK    = 3'h1,
		DIOPC_FN_AOCHK  = 3'h2,
		DIOPC_FN_BOTH   = 3'h3,
		DIOPC_FN_VALID  = 3'h4
	} diopc_fn_t;

	// per output channel configuration, one byte
	typedef struct packed {
		logic        enable;
		logic        invert;
		logic        alarm_en;
		diopc_test_t test;
		diopc_src_t  src;
		logic        spare;
	} diopc_out_cfg_t;

	// per input channel configuration, one byte
	typedef struct packed {
		logic        invert;
		logic        alarm_en;
		diopc_test_t test;
		diopc_fn_t   fn;
		logic        spare;
	} diopc_in_cfg_t;

	// device state feeding the status outputs
	typedef struct packed {
		logic check_run;
		logic warn;
		logic alarm;
		logic reverse;
	} diopc_state_t;

endpackage

/* File: core/diopc_top.sv */
/*
 * discrete i/o conditioning: four status outputs (channel three may be the
 * pulse output), channels five and six as outputs or debounced inputs.
 * assumes axi4-lite on aclk, synchronous field pins, quantity increments
 * delivered as one-cycle strobes from the measurement core.
 */
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
module diopc_top #(
	parameter int CALC_CNT  = diopc_pkg::CALC_CYCLES,
	parameter int MS_CNT    = diopc_pkg::MS_CYCLES,
	parameter int PULSE_HI  = 4
)(
	// clock and reset
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	// axi4-lite slave
	input  wire logic [7:0]              s_axi_awaddr,
	input  wire logic                    s_axi_awvalid,
	output logic                         s_axi_awready,
	input  wire logic [31:0]             s_axi_wdata,
	input  wire logic [3:0]              s_axi_wstrb,
	input  wire logic                    s_axi_wvalid,
	output logic                         s_axi_wready,
	output logic [1:0]                   s_axi_bresp,
	output logic                         s_axi_bvalid,
	input  wire logic                    s_axi_bready,
	input  wire logic [7:0]              s_axi_araddr,
	input  wire logic                    s_axi_arvalid,
	output logic                         s_axi_arready,
	output logic [31:0]                  s_axi_rdata,
	output logic [1:0]                   s_axi_rresp,
	output logic                         s_axi_rvalid,
	input  wire logic                    s_axi_rready,
	// device state and quantity strobes
	input  wire diopc_pkg::diopc_state_t dev_state,
	input  wire logic [3:0]              qty_fwd_inc,
	input  wire logic [5:0]              chan_fault,
	// field pins
	output logic [5:0]                   chan_out,
	output logic [1:0]                   chan_out_oe_n,
	input  wire logic [1:0]              chan_in,
	// functions and alarms
	output logic                         set_maint,
	output logic                         start_chk,
	output logic                         start_ao_chk,
	output logic                         sys_error,
	output logic [15:0]                  err_count
);

	// registers
	logic [31:0] out_ctrl;
	logic [31:0] pulse_ctrl;
	logic [31:0] pulse_fac;
	logic [31:0] in_ctrl;
	logic [31:0] debounce_ms;
	logic [31:0] sys_in;

	diopc_pkg::diopc_out_cfg_t ocfg [6];
	diopc_pkg::diopc_in_cfg_t  icfg [2];
	logic        pulse_mode;
	diopc_pkg::diopc_qty_t pulse_qty;
	logic [7:0]  test_value;
	logic        pulse_test;
	logic [1:0]  in_mode;
	logic        ctrl_bad;

	assign pulse_mode = pulse_ctrl[0];
	assign pulse_test = pulse_ctrl[1];
	assign pulse_qty  = diopc_pkg::diopc_qty_t'(pulse_ctrl[3:2]);
	assign test_value = pulse_ctrl[15:8];
	assign in_mode    = in_ctrl[17:16];
	assign ctrl_bad   = sys_in[0];

	genvar g;
	generate
		for (g = 0; g < 6; g++)
		begin : g_ocfg
			if (g < 4)
			begin : g_lo
				assign ocfg[g] = diopc_pkg::diopc_out_cfg_t'(
					out_ctrl[8*g +: 8]);
			end
			else
			begin : g_hi
				assign ocfg[g] = diopc_pkg::diopc_out_cfg_t'(
					pulse_ctrl[8*(g-2) +: 8]);
			end
		end
		for (g = 0; g < 2; g++)
		begin : g_icfg
			assign icfg[g] = diopc_pkg::diopc_in_cfg_t'(
				in_ctrl[8*g +: 8]);
		end
	endgenerate

	// axi4-lite write path
	logic       aw_held;
	logic       w_held;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        wr_go;

	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	assign wr_go         = aw_held && w_held;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			else if (wr_go)
				aw_held <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			else if (wr_go)
				w_held <= 1'b0;
		end
	end

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (st[i])
				r[8*i +: 8] = nw[8*i +: 8];
		return r;
	endfunction

	logic wr_hit;
	always_comb
	begin
		case (aw_addr)
			diopc_pkg::OFS_OUT_CTRL,
			diopc_pkg::OFS_PULSE_CTRL,
			diopc_pkg::OFS_PULSE_FAC,
			diopc_pkg::OFS_IN_CTRL,
			diopc_pkg::OFS_DEBOUNCE,
			diopc_pkg::OFS_SYS_IN:  wr_hit = 1'b1;
			default:                wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			out_ctrl    <= diopc_pkg::RST_OUT_CTRL;
			pulse_ctrl  <= diopc_pkg::RST_PULSE_CTRL;
			pulse_fac   <= diopc_pkg::RST_PULSE_FAC;
			in_ctrl     <= diopc_pkg::RST_IN_CTRL;
			debounce_ms <= diopc_pkg::RST_DEBOUNCE;
			sys_in      <= 32'h0000_0000;
		end
		else if (wr_go)
		begin
			case (aw_addr)
				diopc_pkg::OFS_OUT_CTRL:
					out_ctrl <= merge(out_ctrl, w_data, w_strb);
				diopc_pkg::OFS_PULSE_CTRL:
					pulse_ctrl <= merge(pulse_ctrl, w_data, w_strb);
				diopc_pkg::OFS_PULSE_FAC:
					pulse_fac <= merge(pulse_fac, w_data, w_strb);
				diopc_pkg::OFS_IN_CTRL:
					in_ctrl <= merge(in_ctrl, w_data, w_strb);
				diopc_pkg::OFS_DEBOUNCE:
					debounce_ms <= merge(debounce_ms, w_data, w_strb);
				diopc_pkg::OFS_SYS_IN:
					sys_in <= merge(sys_in, w_data, w_strb);
				default:
					sys_in <= sys_in;
			endcase
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= diopc_pkg::AXI_OKAY;
		end
		else if (wr_go)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? diopc_pkg::AXI_OKAY
				: diopc_pkg::AXI_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// status and event words
	logic [1:0] in_deb;
	logic [1:0] in_raw;
	logic [1:0] in_eff;
	logic [31:0] status_word;
	logic [31:0] events;

	assign status_word = {14'h0000, err_count[7:0], 1'b0, sys_error,
		in_raw, in_eff, chan_out[3:0]};

	// axi4-lite read path, one cycle after address
	assign s_axi_arready = !s_axi_rvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= diopc_pkg::AXI_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= diopc_pkg::AXI_OKAY;
			case (s_axi_araddr)
				diopc_pkg::OFS_OUT_CTRL:   s_axi_rdata <= out_ctrl;
				diopc_pkg::OFS_PULSE_CTRL: s_axi_rdata <= pulse_ctrl;
				diopc_pkg::OFS_PULSE_FAC:  s_axi_rdata <= pulse_fac;
				diopc_pkg::OFS_PULSE_QTY:  s_axi_rdata <= {30'h0, pulse_qty};
				diopc_pkg::OFS_IN_CTRL:    s_axi_rdata <= in_ctrl;
				diopc_pkg::OFS_DEBOUNCE:   s_axi_rdata <= debounce_ms;
				diopc_pkg::OFS_SYS_IN:     s_axi_rdata <= sys_in;
				diopc_pkg::OFS_STATUS:     s_axi_rdata <= status_word;
				diopc_pkg::OFS_EVENTS:     s_axi_rdata <= events;
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= diopc_pkg::AXI_SLVERR;
				end
			endcase
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// millisecond tick and calculation cycle
	logic [15:0] ms_cnt;
	logic        ms_tick;
	logic [31:0] calc_cnt;
	logic        calc_tick;
	assign ms_tick   = ms_cnt == 16'(MS_CNT - 1);
	assign calc_tick = calc_cnt == 32'(CALC_CNT - 1);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			ms_cnt <= 16'h0000;
		else
			ms_cnt <= ms_tick ? 16'h0000 : ms_cnt + 16'h0001;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			calc_cnt <= 32'h0000_0000;
		else
			calc_cnt <= calc_tick ? 32'h0000_0000 : calc_cnt + 32'h1;
	end

	// pulse generator: factor is 16.16 fixed point
	logic [47:0] acc;
	logic [15:0] pend;
	logic [7:0]  hi_cnt;
	logic        pulse_lvl;
	logic        pulse_go;
	logic        q_hit;
	logic [47:0] acc_sum;
	assign q_hit = qty_fwd_inc[pulse_qty] && !dev_state.reverse;
	assign acc_sum = acc + (q_hit ? {16'h0000, pulse_fac} : 48'h0);
	// pending count drops as a pulse starts, never twice per pulse
	assign pulse_go = hi_cnt == 8'h00 && pend != 16'h0000 && pulse_mode;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			acc  <= 48'h0;
			pend <= 16'h0000;
		end
		else if (!pulse_mode)
		begin
			acc  <= 48'h0;
			pend <= 16'h0000;
		end
		else if (pulse_test)
		begin
			acc  <= 48'h0;
			pend <= pend + (calc_tick ? {8'h00, test_value} : 16'h0000)
				- {15'h0000, pulse_go};
		end
		else
		begin
			acc  <= {32'h0000_0000, acc_sum[15:0]};
			pend <= pend + acc_sum[31:16] - {15'h0000, pulse_go};
		end
	end

	// each pulse high PULSE_HI cycles, low at least PULSE_HI cycles
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			hi_cnt    <= 8'h00;
			pulse_lvl <= 1'b0;
		end
		else if (hi_cnt != 8'h00)
		begin
			hi_cnt <= hi_cnt - 8'h01;
			if (hi_cnt == 8'(PULSE_HI + 1))
				pulse_lvl <= 1'b0;
		end
		else if (pulse_go)
		begin
			pulse_lvl <= 1'b1;
			hi_cnt    <= 8'(2 * PULSE_HI);
		end
	end

	property p_pulse_go;
		@(posedge aclk) disable iff (!aresetn)
		$rose(pulse_lvl) |-> $past(pend) != 16'h0000;
	endproperty
	a_pulse_go: assert property (p_pulse_go) else $error("empty pulse");

	// status outputs
	logic [5:0] next_out;
	always_comb
	begin
		for (int i = 0; i < 6; i++)
		begin
			logic lvl;
			lvl = 1'b0;
			case (ocfg[i].src)
				diopc_pkg::DIOPC_SRC_CHECK: lvl = dev_state.check_run;
				diopc_pkg::DIOPC_SRC_WARN:  lvl = dev_state.warn;
				diopc_pkg::DIOPC_SRC_ALARM: lvl = dev_state.alarm;
				diopc_pkg::DIOPC_SRC_DIR:   lvl = dev_state.reverse;
				default:                    lvl = 1'b0;
			endcase
			lvl = lvl ^ ocfg[i].invert;
			lvl = lvl & ocfg[i].enable;
			if (i == 2 && pulse_mode)
				lvl = pulse_lvl & ocfg[i].enable;
			if (ocfg[i].test == diopc_pkg::DIOPC_TEST_ON)
				lvl = 1'b1;
			else if (ocfg[i].test == diopc_pkg::DIOPC_TEST_LOW)
				lvl = 1'b0;
			next_out[i] = lvl;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			chan_out <= 6'h00;
		else
			chan_out <= next_out;
	end

	// five and six release pins as inputs
	assign chan_out_oe_n = in_mode;

	// inputs: debounce per channel
	generate
		for (g = 0; g < 2; g++)
		begin : g_in
			logic [31:0] stab;
			logic        lvl;
			assign lvl = chan_in[g] ^ icfg[g].invert;
			assign in_raw[g] = lvl;
			always_ff @(posedge aclk)
			begin
				if (!aresetn)
				begin
					stab      <= 32'h0;
					in_deb[g] <= 1'b0;
				end
				else if (lvl == in_deb[g])
					stab <= 32'h0;
				else if (stab >= debounce_ms)
				begin
					in_deb[g] <= lvl;
					stab      <= 32'h0;
				end
				else if (ms_tick)
					stab <= stab + 32'h1;
			end
			property p_deb_hold;
				@(posedge aclk) disable iff (!aresetn)
				in_deb[g] != $past(in_deb[g])
					|-> $past(stab) >= $past(debounce_ms);
			endproperty
			a_deb_hold: assert property (p_deb_hold) else $error("early");
			always_comb
			begin
				case (icfg[g].test)
					diopc_pkg::DIOPC_TEST_ON:  in_eff[g] = in_mode[g];
					diopc_pkg::DIOPC_TEST_LOW: in_eff[g] = 1'b0;
					default: in_eff[g] = in_deb[g] & in_mode[g];
				endcase
			end
		end
	endgenerate

	always_comb
	begin
		set_maint    = 1'b0;
		start_chk    = 1'b0;
		start_ao_chk = 1'b0;
		for (int i = 0; i < 2; i++)
			if (in_eff[i])
				case (icfg[i].fn)
					diopc_pkg::DIOPC_FN_MAINT: set_maint = 1'b1;
					diopc_pkg::DIOPC_FN_CHK:   start_chk = 1'b1;
					diopc_pkg::DIOPC_FN_AOCHK: start_ao_chk = 1'b1;
					diopc_pkg::DIOPC_FN_BOTH:
					begin
						start_chk    = 1'b1;
						start_ao_chk = 1'b1;
					end
					default: set_maint = set_maint;
				endcase
	end

	property p_fn_both;
		@(posedge aclk) disable iff (!aresetn)
		in_eff[0] && icfg[0].fn == diopc_pkg::DIOPC_FN_BOTH
			|-> start_chk && start_ao_chk;
	endproperty
	a_fn_both: assert property (p_fn_both) else $error("both");

	// alarms and error counter
	logic [5:0] ch_alarm;
	logic       bad_valid;
	always_comb
	begin
		for (int i = 0; i < 6; i++)
			ch_alarm[i] = chan_fault[i] && ocfg[i].alarm_en;
		bad_valid = 1'b0;
		for (int i = 0; i < 2; i++)
		begin
			if (in_mode[i] && chan_fault[4+i] && icfg[i].alarm_en)
				ch_alarm[4+i] = 1'b1;
			if (in_mode[i] && icfg[i].fn == diopc_pkg::DIOPC_FN_VALID
				&& (in_eff[i] ? 1'b0 : 1'b1) && ctrl_bad)
				bad_valid = 1'b1;
		end
	end

	assign events = {26'h0, ch_alarm};

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			sys_error <= 1'b0;
		else
			sys_error <= |ch_alarm;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			err_count <= 16'h0000;
		else if ((|ch_alarm || bad_valid) && calc_tick
			&& err_count != 16'hFFFF)
			err_count <= err_count + 16'h0001;
	end

	property p_err_step;
		@(posedge aclk) disable iff (!aresetn)
		err_count != $past(err_count) |-> $past(calc_tick);
	endproperty
	a_err_step: assert property (p_err_step) else $error("count");

	property p_test_on;
		@(posedge aclk) disable iff (!aresetn)
		ocfg[0].test == diopc_pkg::DIOPC_TEST_ON |=> chan_out[0];
	endproperty
	a_test_on: assert property (p_test_on) else $error("test on");

	property p_test_low;
		@(posedge aclk) disable iff (!aresetn)
		ocfg[0].test == diopc_pkg::DIOPC_TEST_LOW |=> !chan_out[0];
	endproperty
	a_test_low: assert property (p_test_low) else $error("test low");

	property p_sys_err;
		@(posedge aclk) disable iff (!aresetn)
		chan_fault[0] && ocfg[0].alarm_en |=> sys_error;
	endproperty
	a_sys_err: assert property (p_sys_err) else $error("alarm");
endmodule

/* File: sim/diopc_plant.sv */
/*
 * plant control side of the discrete field wiring.
 * assumes the bench sets the levels the plant drives on ch5/6.
 */
`timescale 1ns/1ps
module diopc_plant (
	// clock
	input  wire logic        aclk,
	// field pins
	input  wire logic [5:0]  chan_out,
	input  wire logic [1:0]  chan_out_oe_n,
	output logic [1:0]       chan_in,
	// bench side
	input  wire logic [1:0]  plant_level,
	input  wire logic        pulse_clr,
	output logic [15:0]      pulse_count
);
	logic pulse_last;

	assign chan_in = (chan_out_oe_n & plant_level)
		| (~chan_out_oe_n & chan_out[5:4]);

	// count rising edges of the pulse pin
	always_ff @(posedge aclk)
	begin
		pulse_last <= chan_out[2];
		if (pulse_clr)
			pulse_count <= 16'h0000;
		else if (chan_out[2] && !pulse_last)
			pulse_count <= pulse_count + 16'h0001;
	end
endmodule

/* File: sim/diopc_bench.sv */
/*
 * register-level bench of the discrete i/o and pulse block.
 * assumes diopc_top with short calculation cycle and millisecond, and the
 * plant model.
 */
`timescale 1ns/1ps
module diopc_bench;
	logic                    aclk, aresetn;
	logic [7:0]              s_axi_awaddr, s_axi_araddr;
	logic [31:0]             s_axi_wdata, s_axi_rdata;
	logic [3:0]              s_axi_wstrb, qty_fwd_inc;
	logic [1:0]              s_axi_bresp, s_axi_rresp;
	logic                    s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic                    s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                    s_axi_arvalid, s_axi_arready;
	logic                    s_axi_rvalid, s_axi_rready;
	diopc_pkg::diopc_state_t dev_state;
	logic [5:0]              chan_fault, chan_out;
	logic [1:0]              chan_out_oe_n, chan_in, plant_level;
	logic                    set_maint, start_chk, start_ao_chk;
	logic                    sys_error, pulse_clr;
	logic [15:0]             err_count, pulse_count, e0;
	logic [31:0]             d;
	logic [1:0]              r;
	logic [2:0]              fx [4] = '{3'b100, 3'b010, 3'b001, 3'b011};
	int                      fails, checks_done, n;

	diopc_top #(.CALC_CNT(100), .MS_CNT(1000), .PULSE_HI(4))
	DUT (.aclk, .aresetn,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .dev_state, .qty_fwd_inc, .chan_fault, .chan_out,
		.chan_out_oe_n, .chan_in, .set_maint, .start_chk, .start_ao_chk,
		.sys_error, .err_count);

	diopc_plant plant (.aclk, .chan_out, .chan_out_oe_n, .chan_in,
		.plant_level, .pulse_clr, .pulse_count);

	initial aclk = 1'b0;
	always #12.5 aclk = ~aclk;

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED at %0t: %s got %h want %h",
				$time, msg, got, exp);
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge aclk);
	endtask

	// handshakes judged on pre-edge values, released by nba at that edge
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		output logic [1:0] rs);
		int k;
		logic b;
		k = 0;
		b = 1'b0;
		rs = 2'h0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b && k < 100)
		begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
			begin
				b = 1'b1;
				rs = s_axi_bresp;
				s_axi_bready <= 1'b0;
			end
			k++;
		end
		if (!b) check(1'b0, 1'b1, "write timeout");
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v,
		output logic [1:0] rs);
		int k;
		logic b;
		k = 0;
		b = 1'b0;
		v = 32'h0000_0000;
		rs = 2'h0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!b && k < 100)
		begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
			begin
				b = 1'b1;
				v = s_axi_rdata;
				rs = s_axi_rresp;
				s_axi_rready <= 1'b0;
			end
			k++;
		end
		if (!b) check(1'b0, 1'b1, "read timeout");
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] rs;
		wr(a, v, rs);
	endtask

	function automatic logic [7:0] ob(input logic en, input logic inv,
		input logic alm, input logic [1:0] tst, input logic [1:0] sr);
		return {en, inv, alm, tst, sr, 1'b0};
	endfunction

	// input byte with both ch5/6 in input mode
	function automatic logic [31:0] ib(input logic inv, input logic alm,
		input logic [1:0] tst, input logic [2:0] fn);
		return {14'h0000, 2'b11, 8'h00, inv, alm, tst, fn, 1'b0};
	endfunction

	initial
	begin
		cyc(15000);
		fails++;
		give_verdict();
	end

	initial
	begin
		aresetn = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		dev_state = 4'h0;
		qty_fwd_inc = 4'h0;
		chan_fault = 6'h00;
		plant_level = 2'h0;
		pulse_clr = 1'b1;
		cyc(20);
		aresetn <= 1'b1;
		pulse_clr <= 1'b0;

		rd(diopc_pkg::OFS_OUT_CTRL, d, r);
		check(d, diopc_pkg::RST_OUT_CTRL, "out reset");
		rd(diopc_pkg::OFS_PULSE_CTRL, d, r);
		check(d, diopc_pkg::RST_PULSE_CTRL, "pulse ctrl reset");
		rd(diopc_pkg::OFS_PULSE_FAC, d, r);
		check(d, diopc_pkg::RST_PULSE_FAC, "factor reset");
		rd(diopc_pkg::OFS_IN_CTRL, d, r);
		check(d, diopc_pkg::RST_IN_CTRL, "in reset");
		rd(8'h40, d, r);
		check(d, 32'h0000_0000, "unmapped read data");
		check(r, diopc_pkg::AXI_SLVERR, "unmapped read");
		wr(8'h40, 32'h0000_0001, r);
		check(r, diopc_pkg::AXI_SLVERR, "unmapped write");
		wreg(diopc_pkg::OFS_DEBOUNCE, 32'h0000_0005);
		rd(diopc_pkg::OFS_DEBOUNCE, d, r);
		check(d, 32'h0000_0005, "debounce rw");
		check(r, diopc_pkg::AXI_OKAY, "debounce resp");
		wreg(diopc_pkg::OFS_DEBOUNCE, 32'h0000_0000);
		$display("test registers done");

		for (int s = 0; s < 4; s++)
			for (int i = 0; i < 4; i++)
			begin
				dev_state <= i[1] ? (4'h8 >> s) : 4'h0;
				wreg(diopc_pkg::OFS_OUT_CTRL, {ob(1'b0, 1'b0, 1'b0, 2'h0, s[1:0]),
					{3{ob(1'b1, i[0], 1'b0, 2'h0, s[1:0])}}});
				cyc(4);
				check(chan_out[3:0], {1'b0, {3{i[1] ^ i[0]}}}, "status");
			end
		dev_state <= 4'h0;
		for (int t = 1; t < 3; t++)
		begin
			wreg(diopc_pkg::OFS_OUT_CTRL, {24'h0, ob(1'b1, t == 2, 1'b0, t[1:0],
				2'h0)});
			cyc(4);
			check(chan_out[0], t == 1, "forced output");
		end
		wreg(diopc_pkg::OFS_PULSE_CTRL, {ob(1'b1, 1'b1, 1'b0, 2'h0, 2'h0),
			ob(1'b1, 1'b0, 1'b0, 2'h0, 2'h0), 16'h0000});
		cyc(4);
		check({chan_out_oe_n, chan_out[5:4]}, 4'h2, "five six out");
		wreg(diopc_pkg::OFS_PULSE_CTRL, 32'h0000_0000);
		$display("test status outputs done");

		chan_fault <= 6'h11;
		wreg(diopc_pkg::OFS_IN_CTRL, ib(1'b0, 1'b0, 2'h0, 3'h0));
		wreg(diopc_pkg::OFS_OUT_CTRL, {24'h0, ob(1'b1, 1'b0, 1'b0, 2'h0, 2'h0)});
		cyc(4);
		check(sys_error, 1'b0, "no alarm enabled");
		wreg(diopc_pkg::OFS_OUT_CTRL, {24'h0, ob(1'b1, 1'b0, 1'b1, 2'h0, 2'h0)});
		cyc(4);
		check(sys_error, 1'b1, "output alarm");
		wreg(diopc_pkg::OFS_OUT_CTRL, 32'h0000_0000);
		wreg(diopc_pkg::OFS_IN_CTRL, ib(1'b0, 1'b1, 2'h0, 3'h0));
		cyc(4);
		check(sys_error, 1'b1, "input alarm");
		rd(diopc_pkg::OFS_EVENTS, d, r);
		check(d, 32'h0000_0010, "alarm source");
		chan_fault <= 6'h00;
		$display("test alarms done");

		check(chan_out_oe_n, 2'b11, "inputs released");
		for (int f = 0; f < 4; f++)
			for (int l = 0; l < 2; l++)
			begin
				plant_level <= {1'b0, l[0]};
				wreg(diopc_pkg::OFS_IN_CTRL, ib(1'b0, 1'b0, 2'h0, f[2:0]));
				cyc(8);
				check({set_maint, start_chk, start_ao_chk},
					l ? fx[f] : 3'b000, "function");
			end
		for (int k = 0; k < 3; k++)
		begin
			plant_level <= {1'b0, k == 2};
			wreg(diopc_pkg::OFS_IN_CTRL, ib(k == 0, 1'b0, k[1:0], 3'h0));
			cyc(8);
			check(set_maint, k < 2, "invert and test");
		end
		$display("test inputs done");

		plant_level <= 2'h0;
		wreg(diopc_pkg::OFS_IN_CTRL, ib(1'b0, 1'b0, 2'h0, 3'h4));
		cyc(20);
		e0 = err_count;
		cyc(300);
		check(err_count, e0, "count idle");
		wreg(diopc_pkg::OFS_SYS_IN, 32'h0000_0001);
		cyc(350);
		e0 = err_count - e0;
		check(e0 >= 3 && e0 <= 4, 1'b1, "bad status counted");
		wreg(diopc_pkg::OFS_SYS_IN, 32'h0000_0000);
		$display("test data valid done");

		wreg(diopc_pkg::OFS_OUT_CTRL, {8'h0, ob(1'b1, 1'b0, 1'b0, 2'h0, 2'h0),
			16'h0});
		wreg(diopc_pkg::OFS_PULSE_FAC, 32'h0001_4000);
		for (int q = 0; q < 4; q++)
		begin
			wreg(diopc_pkg::OFS_PULSE_CTRL, {28'h0, q[1:0], 2'b01});
			pulse_clr <= 1'b1;
			cyc(1);
			pulse_clr <= 1'b0;
			for (int k = 0; k < 8; k++)
			begin
				qty_fwd_inc <= (k < 4) ? 4'hF : ~(4'h1 << q);
				cyc(1);
				qty_fwd_inc <= 4'h0;
				cyc(2);
			end
			cyc(600);
			check(pulse_count, 16'h0005, "pulses per quantity");
		end
		wreg(diopc_pkg::OFS_PULSE_CTRL, 32'h0000_0303);
		pulse_clr <= 1'b1;
		cyc(1);
		pulse_clr <= 1'b0;
		cyc(1000);
		check(pulse_count >= 27 && pulse_count <= 33, 1'b1, "test pulses");
		wreg(diopc_pkg::OFS_PULSE_CTRL, 32'h0000_0000);
		$display("test pulse done");

		// two ms keeps the tick phase from hiding a short glitch
		wreg(diopc_pkg::OFS_DEBOUNCE, 32'h0000_0002);
		wreg(diopc_pkg::OFS_IN_CTRL, ib(1'b0, 1'b0, 2'h0, 3'h0));
		plant_level <= 2'h1;
		cyc(20);
		rd(diopc_pkg::OFS_STATUS, d, r);
		check(d[7:4], 4'h4, "raw level");
		cyc(450);
		check(set_maint, 1'b0, "short level ignored");
		plant_level <= 2'h0;
		cyc(10);
		plant_level <= 2'h1;
		n = 0;
		while (set_maint !== 1'b1 && n < 3000)
		begin
			cyc(1);
			n++;
		end
		check(n >= 1000 && n <= 2010, 1'b1, "debounce time");
		$display("test debounce done");
		give_verdict();
	end
endmodule
